// >>> hdl/ccpw_pkg.sv
// Package with register map, field layout and timing constants for the PWM unit
package ccpw_pkg;
  // Register byte addresses (word aligned)
  localparam logic [7:0] ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_PERIOD    = 8'h04;
  localparam logic [7:0] ADDR_DUTY      = 8'h08;
  localparam logic [7:0] ADDR_DUTYLATCH = 8'h0C;
  localparam logic [7:0] ADDR_PAIRSEL   = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;
  localparam logic [7:0] ADDR_PRESCALE  = 8'h18;

  // Control register fields
  localparam int          CTRL_MODE_LSB   = 0;
  localparam int          CTRL_DUTYLO_LSB = 4;
  localparam logic [3:0]  MODE_PWM        = 4'hC;
  localparam logic [7:0]  CONTROL_RESET   = 8'h00;

  // Timer pairing register fields
  localparam int          PAIR8_LSB       = 0;
  localparam int          PAIR9_BIT       = 2;
  localparam int          PAIR10_BIT      = 4;
  localparam logic [7:0]  PAIRSEL_MASK    = 8'h17;
  localparam logic [7:0]  PAIRSEL_RESET   = 8'h00;
  localparam logic [7:0]  PERIOD_RESET    = 8'hFF;

  // Pairing field codes
  localparam logic [1:0]  PAIR8_T1_T2     = 2'h0;
  localparam logic [1:0]  PAIR8_T3_T4     = 2'h1;
  localparam logic [1:0]  PAIR8_T3_T6     = 2'h2;

  // Timer pair encodings driven on the unit timer pair outputs: {clock-source timer, period timer}
  localparam logic [3:0]  PAIR_T1_T2      = 4'h0;
  localparam logic [3:0]  PAIR_T3_T4      = 4'h1;
  localparam logic [3:0]  PAIR_T3_T6      = 4'h2;
  localparam logic [3:0]  PAIR_T5_T2      = 4'h3;
  localparam logic [3:0]  PAIR_T5_T4      = 4'h4;
  localparam logic [3:0]  PAIR_NONE       = 4'hF;

  // Prescale codes: 1, 4, 16
  localparam logic [1:0]  PRE_1           = 2'h0;
  localparam logic [1:0]  PRE_4           = 2'h1;
  localparam logic [1:0]  PRE_16          = 2'h2;
  localparam logic [1:0]  PRE_RSVD        = 2'h3;
  localparam logic [3:0]  PRE4_LIMIT      = 4'h3;
  localparam logic [3:0]  PRE16_LIMIT     = 4'hF;

  // One time-base phase equals one oscillator period times the prescale; four phases per timer tick
  localparam int          CLOCK_MHZ       = 100;
  localparam int          TOSC_NS         = 10;
  localparam int          TOSC_CYCLES     = (TOSC_NS * CLOCK_MHZ) / 1000 < 1 ? 1 :
                                            (TOSC_NS * CLOCK_MHZ) / 1000;
  localparam int          PHASES_PER_TICK = 4;
endpackage : ccpw_pkg

// >>> hdl/ccpw_tick_if.sv
// Interface carrying the time-base tick and phase between divider and PWM core
`timescale 1ns/1ps
interface ccpw_tick_if;
  logic       tick;
  logic       step;
  logic [1:0] phase;
  logic       clear;
  logic [1:0] prescale;
  modport source (output tick, output step, output phase, input clear, input prescale);
  modport sink   (input tick, input step, input phase, output clear, output prescale);
endinterface : ccpw_tick_if

// >>> hdl/ccpw_prescaler.sv
// Oscillator-period divider and prescaler producing the 2 low time-base bits
`timescale 1ns/1ps
module ccpw_prescaler
  import ccpw_pkg::*;
(
  input  wire logic    clock,
  input  wire logic    reset_n,
  ccpw_tick_if.source  tb
);
  logic [7:0] oscCount;
  logic [3:0] preCount;
  logic       oscEn;
  logic [3:0] preLimit;

  always_comb begin
    unique case (tb.prescale)
      PRE_4:   preLimit = PRE4_LIMIT;
      PRE_16:  preLimit = PRE16_LIMIT;
      default: preLimit = 4'h0;
    endcase
  end

  assign oscEn = (oscCount == 8'(TOSC_CYCLES - 1));

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      oscCount <= 8'h00;
    end else if (tb.clear || oscEn) begin
      oscCount <= 8'h00;
    end else begin
      oscCount <= oscCount + 8'h01;
    end
  end

  // Phase advances every Tosc times prescale; low bits of time base
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      preCount <= 4'h0;
      tb.phase <= 2'h0;
    end else if (tb.clear) begin
      preCount <= 4'h0;
      tb.phase <= 2'h0;
    end else if (oscEn) begin
      if (preCount >= preLimit) begin
        preCount <= 4'h0;
        tb.phase <= tb.phase + 2'h1;
      end else begin
        preCount <= preCount + 4'h1;
      end
    end
  end

  // Step marks the cycle on which the phase is about to advance
  assign tb.step = oscEn && (preCount >= preLimit);
  assign tb.tick = tb.step && (tb.phase == 2'(PHASES_PER_TICK - 1));
endmodule : ccpw_prescaler

// >>> hdl/ccpw_pwm_unit.sv
// PWM unit with 10-bit time base, period match, duty latch and timer pairing select
`timescale 1ns/1ps
// What this block does
// - Unit 8 pairing field: 00,01,10 choose timers
// - Units 10 and 9 single-bit timer selects
// - PWM output up to 10-bit resolution
// - Zeroing control register forces output low
// - Time base: 8-bit timer plus 2 bits
// - Period is (period+1)*4*Tosc*prescale
// - Timer clears after matching period register
// - Zero duty keeps output low all period
// - Duty latched at each period match
// - High for duty portion, low remainder
module ccpw_pwm_unit
  import ccpw_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pinDirectionBit,
  output logic             pwmOut,
  output logic             pwmOutEn,
  output logic [3:0]       unit8TimerPair,
  output logic [3:0]       unit9TimerPair,
  output logic [3:0]       unit10TimerPair
);
  ccpw_tick_if tb ();

  logic [7:0] unitControlRegister;
  logic [7:0] periodRegister;
  logic [7:0] dutyWriteRegister;
  logic [9:0] dutyLatch;
  logic [7:0] unitTimerPairingSelect2;
  logic [1:0] prescaleSel;
  logic [7:0] eightBitBaseTimer;
  logic       outLatch;
  logic       periodMatch;
  logic       pwmMode;
  logic       restart;
  logic [9:0] timeBase;
  logic [9:0] dutyRequest;
  logic       wrEn;
  logic       rdEn;
  logic       addrOk;

  ccpw_prescaler u_prescaler (
    .clock   (clock),
    .reset_n (reset_n),
    .tb      (tb.source)
  );

  assign pwmMode     = (unitControlRegister[CTRL_MODE_LSB +: 4] == MODE_PWM);
  assign timeBase    = {eightBitBaseTimer, tb.phase};
  assign dutyRequest = {dutyWriteRegister, unitControlRegister[CTRL_DUTYLO_LSB +: 2]};
  assign periodMatch = (eightBitBaseTimer == periodRegister);
  assign restart     = tb.tick && periodMatch;
  assign tb.clear    = !pwmMode;
  assign tb.prescale = prescaleSel;

  // APB: zero wait states, unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign wrEn    = psel && penable && pwrite;
  assign rdEn    = psel && !penable && !pwrite;
  always_comb begin
    unique case (paddr)
      ADDR_CONTROL, ADDR_PERIOD, ADDR_DUTY, ADDR_DUTYLATCH,
      ADDR_PAIRSEL, ADDR_STATUS, ADDR_PRESCALE: addrOk = 1'b1;
      default:                                  addrOk = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !addrOk;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      unitControlRegister <= CONTROL_RESET;
    end else if (wrEn && paddr == ADDR_CONTROL) begin
      unitControlRegister <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      periodRegister    <= PERIOD_RESET;
      dutyWriteRegister <= 8'h00;
      prescaleSel       <= PRE_1;
    end else if (wrEn) begin
      if (paddr == ADDR_PERIOD) begin
        periodRegister <= pwdata[7:0];
      end
      if (paddr == ADDR_DUTY) begin
        dutyWriteRegister <= pwdata[7:0];
      end
      if (paddr == ADDR_PRESCALE) begin
        prescaleSel <= (pwdata[1:0] == PRE_RSVD) ? PRE_16 : pwdata[1:0];
      end
    end
  end

  // Unimplemented bits never stored, so they read as zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      unitTimerPairingSelect2 <= PAIRSEL_RESET;
    end else if (wrEn && paddr == ADDR_PAIRSEL) begin
      unitTimerPairingSelect2 <= pwdata[7:0] & PAIRSEL_MASK;
    end
  end

  // Timer pair decode; reserved unit 8 code reports no pair
  always_comb begin
    unique case (unitTimerPairingSelect2[PAIR8_LSB +: 2])
      PAIR8_T1_T2: unit8TimerPair = PAIR_T1_T2;
      PAIR8_T3_T4: unit8TimerPair = PAIR_T3_T4;
      PAIR8_T3_T6: unit8TimerPair = PAIR_T3_T6;
      default:     unit8TimerPair = PAIR_NONE;
    endcase
    unit9TimerPair  = unitTimerPairingSelect2[PAIR9_BIT]  ? PAIR_T5_T4 : PAIR_T1_T2;
    unit10TimerPair = unitTimerPairingSelect2[PAIR10_BIT] ? PAIR_T5_T2 : PAIR_T1_T2;
  end

  // Timer clears on the increment after matching the period
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      eightBitBaseTimer <= 8'h00;
    end else if (!pwmMode) begin
      eightBitBaseTimer <= 8'h00;
    end else if (restart) begin
      eightBitBaseTimer <= 8'h00;
    end else if (tb.tick) begin
      eightBitBaseTimer <= eightBitBaseTimer + 8'h01;
    end
  end

  // Duty copied every cycle outside PWM mode and in PWM mode only at restart, so a period never sees a torn value
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dutyLatch <= 10'h000;
    end else if (!pwmMode) begin
      dutyLatch <= dutyRequest;
    end else if (restart) begin
      dutyLatch <= dutyRequest;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      outLatch <= 1'b0;
    end else if (unitControlRegister == CONTROL_RESET || !pwmMode) begin
      outLatch <= 1'b0;
    end else if (restart) begin
      outLatch <= (dutyRequest != 10'h000);
    end else if (tb.step && timeBase + 10'h001 >= dutyLatch) begin
      // Fall only as the phase advances, so slow prescales keep full duty
      outLatch <= 1'b0;
    end
  end

  // Pin carries the waveform only while the direction bit selects output
  assign pwmOut   = outLatch;
  assign pwmOutEn = !pinDirectionBit;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn) begin
      unique case (paddr)
        ADDR_CONTROL:   prdata <= {24'h000000, unitControlRegister};
        ADDR_PERIOD:    prdata <= {24'h000000, periodRegister};
        ADDR_DUTY:      prdata <= {24'h000000, dutyWriteRegister};
        ADDR_DUTYLATCH: prdata <= {22'h0, dutyLatch};
        ADDR_PAIRSEL:   prdata <= {24'h000000, unitTimerPairingSelect2};
        ADDR_STATUS:    prdata <= {20'h00000, outLatch, 1'b0, tb.phase, eightBitBaseTimer};
        ADDR_PRESCALE:  prdata <= {30'h0, prescaleSel};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  chk_timer_clear: assert property (@(posedge clock) disable iff (!reset_n)
    restart |=> eightBitBaseTimer == 8'h00)
    else $error("timer not cleared after period match");
  chk_output_set: assert property (@(posedge clock) disable iff (!reset_n)
    (restart && pwmMode && unitControlRegister != CONTROL_RESET && dutyRequest != 10'h000)
      |=> outLatch)
    else $error("output not set at period start");
  chk_zero_duty: assert property (@(posedge clock) disable iff (!reset_n)
    (restart && dutyRequest == 10'h000) |=> !outLatch)
    else $error("zero duty set the output");
  chk_duty_latch: assert property (@(posedge clock) disable iff (!reset_n)
    (pwmMode && !restart) |=> dutyLatch == $past(dutyLatch))
    else $error("duty latch changed mid period");
  chk_duty_copy: assert property (@(posedge clock) disable iff (!reset_n)
    restart |=> dutyLatch == $past(dutyRequest))
    else $error("duty not latched at period match");
  chk_control_zero: assert property (@(posedge clock) disable iff (!reset_n)
    (wrEn && paddr == ADDR_CONTROL && pwdata[7:0] == 8'h00) |=> ##1 !outLatch)
    else $error("output not forced low on control clear");
  chk_duty_fall: assert property (@(posedge clock) disable iff (!reset_n)
    (pwmMode && !restart && tb.step && timeBase + 10'h001 >= dutyLatch) |=> !outLatch)
    else $error("output high past duty");
  chk_unit8_pair: assert property (@(posedge clock) disable iff (!reset_n)
    unitTimerPairingSelect2[1:0] == PAIR8_T3_T6 |-> unit8TimerPair == PAIR_T3_T6)
    else $error("unit 8 pairing decode wrong");
  chk_unit_pairs: assert property (@(posedge clock) disable iff (!reset_n)
    unitTimerPairingSelect2[PAIR10_BIT] |-> unit10TimerPair == PAIR_T5_T2)
    else $error("unit 10 pairing decode wrong");
  chk_time_base: assert property (@(posedge clock) disable iff (!reset_n)
    timeBase[9:2] == eightBitBaseTimer)
    else $error("time base upper bits wrong");

  cov_restart:   cover property (@(posedge clock) disable iff (!reset_n) restart ##1 outLatch);
  cov_fall:      cover property (@(posedge clock) disable iff (!reset_n) $fell(outLatch));
  cov_zero_duty: cover property (@(posedge clock) disable iff (!reset_n)
    restart && dutyRequest == 10'h000);
endmodule : ccpw_pwm_unit

// >>> tb/test_ccp_pwm_timer_select.sv
// Self-checking testbench for the PWM unit and its timer pairing select
`timescale 1ns/1ps
module test_ccp_pwm_timer_select;
  import ccpw_pkg::*;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pinDirectionBit = 1'b1;
  logic        pwmOut;
  logic        pwmOutEn;
  logic [3:0]  unit8TimerPair;
  logic [3:0]  unit9TimerPair;
  logic [3:0]  unit10TimerPair;
  int          miscompares = 0;
  int          totalChecks = 0;

  ccpw_pwm_unit i_ccpw_pwm_unit (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pinDirectionBit(pinDirectionBit), .pwmOut(pwmOut), .pwmOutEn(pwmOutEn),
    .unit8TimerPair(unit8TimerPair), .unit9TimerPair(unit9TimerPair),
    .unit10TimerPair(unit10TimerPair));

  always #5 clock = ~clock;

  task automatic chk(input string name, input logic [31:0] expv, input logic [31:0] got);
    totalChecks++;
    if (got !== expv) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, expv, got);
    end
  endtask : chk

  // Request held until pready is sampled high; data taken at that edge only
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask : wr

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] expv);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(name, expv, r);
  endtask : rdchk

  // Rising edge to rising edge of the output, counting high cycles
  task automatic measure(output int per, output int hi);
    logic prev;
    int   n;
    n = 0; per = 0; hi = 0;
    // Skip past any edge still settling when called
    #1;
    do begin prev = pwmOut; @(posedge clock); #1; n++; end
    while (!(prev === 1'b0 && pwmOut === 1'b1) && n < 2000);
    do begin hi += (pwmOut === 1'b1); prev = pwmOut; @(posedge clock); #1; per++; end
    while (!(prev === 1'b0 && pwmOut === 1'b1) && per < 2000);
  endtask : measure

  task automatic test_reset;
    chk("pwmOut", 32'h0, {31'h0, pwmOut});
    chk("pwmOutEn dir1", 32'h0, {31'h0, pwmOutEn});
    @(posedge clock);
    pinDirectionBit <= 1'b0;
    rdchk("period rst", ADDR_PERIOD, 32'hFF);
    rdchk("pairsel rst", ADDR_PAIRSEL, {24'h0, PAIRSEL_RESET});
    rdchk("control rst", ADDR_CONTROL, {24'h0, CONTROL_RESET});
    chk("pwmOutEn dir0", 32'h1, {31'h0, pwmOutEn});
    $display("test_reset done");
  endtask : test_reset

  task automatic test_pairing;
    logic [3:0]  exp8 [3];
    logic [7:0]  v;
    logic [31:0] r;
    logic        e;
    exp8 = '{PAIR_T1_T2, PAIR_T3_T4, PAIR_T3_T6};
    for (int i = 0; i < 3; i++) begin // reserved unit 8 code never written
      v = {3'b111, i[0], 1'b1, i[1], i[1:0]};
      wr(ADDR_PAIRSEL, v);
      rdchk("pairsel rd", ADDR_PAIRSEL, {24'h0, v & PAIRSEL_MASK});
      chk("unit8 pair", {28'h0, exp8[i]}, {28'h0, unit8TimerPair});
      chk("unit9 pair", {28'h0, i[1] ? PAIR_T5_T4 : PAIR_T1_T2},
          {28'h0, unit9TimerPair});
      chk("unit10 pair", {28'h0, i[0] ? PAIR_T5_T2 : PAIR_T1_T2},
          {28'h0, unit10TimerPair});
    end
    apb(1'b0, 8'h1C, 32'h0, r, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
    $display("test_pairing done");
  endtask : test_pairing

  // Duty 6 of period (3+1)*4 at prescale 1, then prescale 4
  task automatic test_period;
    int per;
    int hi;
    wr(ADDR_PRESCALE, {6'h0, PRE_1});
    wr(ADDR_PERIOD, 8'h03);
    wr(ADDR_DUTY, 8'h01);
    wr(ADDR_CONTROL, 8'h20 | {4'h0, MODE_PWM});
    measure(per, hi);
    chk("period pre1", 32'd16, per);
    chk("high pre1", 32'd6, hi);
    rdchk("duty latch", ADDR_DUTYLATCH, 32'h06);
    wr(ADDR_PRESCALE, {6'h0, PRE_4});
    measure(per, hi);
    measure(per, hi);
    chk("period pre4", 32'd64, per);
    chk("high pre4", 32'd24, hi);
    wr(ADDR_DUTY, 8'h03);
    measure(per, hi);
    measure(per, hi);
    chk("high new duty", 32'd56, hi);
    rdchk("duty latch new", ADDR_DUTYLATCH, 32'h0E);
    $display("test_period done");
  endtask : test_period

  task automatic test_zero_and_off;
    int hi;
    int n;
    wr(ADDR_PRESCALE, {6'h0, PRE_1});
    wr(ADDR_DUTY, 8'h00);
    wr(ADDR_CONTROL, {4'h0, MODE_PWM});
    repeat (40) @(posedge clock);
    hi = 0;
    repeat (48) begin @(posedge clock); #1; hi += (pwmOut === 1'b1); end
    chk("zero duty highs", 32'd0, hi);
    wr(ADDR_DUTY, 8'h02);
    n = 0;
    while (pwmOut !== 1'b1 && n < 200) begin @(posedge clock); #1; n++; end
    chk("running high", 32'h1, {31'h0, pwmOut});
    wr(ADDR_CONTROL, 8'h00);
    repeat (2) @(posedge clock);
    hi = 0;
    repeat (40) begin @(posedge clock); #1; hi += (pwmOut === 1'b1); end
    chk("off highs", 32'd0, hi);
    rdchk("status off", ADDR_STATUS, 32'h0);
    $display("test_zero_and_off done");
  endtask : test_zero_and_off

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    $display("[ERR] watchdog expected finish seen timeout");
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    #1;
    test_reset();
    test_pairing();
    test_period();
    test_zero_and_off();
    end_of_test();
  end
endmodule : test_ccp_pwm_timer_select
